//--- hw/ssm_shift_master.sv
// Purpose: Bit-serial synchronous shift master on two assignable pins
// Assumes: Commands from logic on mclk; pin inputs are asynchronous
// Notes:   Chip select is a separate manual output, untouched by the shifter
`timescale 1ns/1ps

`include "ssm_params.svh"

module ssm_shift_master #(
	parameter int STRETCH_US = `SSM_STRETCH_US
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             cmd_valid,
	output logic                  cmd_ready,
	input  wire logic             cmd_rx,
	input  wire logic [2:0]       cmd_mode,
	input  wire ssm_pkg::ssm_bits_t cmd_bits,
	input  wire ssm_pkg::ssm_word_t cmd_data,
	input  wire ssm_pkg::ssm_pin_t  clk_pin_sel,
	input  wire ssm_pkg::ssm_pin_t  data_pin_sel,
	input  wire logic             sel_assert,
	output logic                  sel_n,
	output logic                  busy,
	output logic                  rx_valid,
	output ssm_pkg::ssm_word_t      rx_data,
	input  wire ssm_pkg::ssm_pins_t gpio_in,
	output ssm_pkg::ssm_pins_t      gpio_out,
	output ssm_pkg::ssm_pins_t      gpio_oe
);
	import ssm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Phase lengths

	localparam logic [`SSM_CNTW-1:0] ACT_CYC = `SSM_CNTW'(
		(`SSM_ACT_NS + STRETCH_US * `SSM_NS_PER_US + `SSM_CYC_NS - 1) / `SSM_CYC_NS);
	localparam logic [`SSM_CNTW-1:0] IDLE_CYC = `SSM_CNTW'(
		(`SSM_PERIOD_NS - `SSM_ACT_NS) / `SSM_CYC_NS);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		ssm_state_t            st;
		logic [`SSM_CNTW-1:0]  cnt;
		ssm_bits_t             idx;
		ssm_bits_t             nbits;
		ssm_word_t             sh;
		logic                  rx;
		logic [2:0]            mode;
		ssm_pin_t              clk_pin;
		ssm_pin_t              dat_pin;
		ssm_pins_t             pin_out;
		ssm_pins_t             pin_oe;
		ssm_word_t             rx_word;
		logic                  rx_pulse;
		logic                  sel_n;
		ssm_pins_t             sync1;
		ssm_pins_t             sync2;
	} ssm_st_t;

	ssm_st_t  s_reg;
	ssm_st_t  s_next;
	ssm_cmd_t fifo_in;
	ssm_cmd_t item;
	logic     item_valid;
	logic     take;

	////////////////////////////////////////////////////////////////////////////////
	// Command queue

	assign fifo_in = '{rx: cmd_rx, mode: cmd_mode, bits: cmd_bits, data: cmd_data};

	ssm_fifo #(
		.WIDTH ($bits(ssm_cmd_t)),
		.DEPTH (`SSM_FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   (fifo_in),
		.out_valid (item_valid),
		.out_ready (take),
		.out_data  (item)
	);

	// Next item is taken as soon as the previous one ends
	assign take = (s_reg.st == SSM_IDLE) && item_valid;

	////////////////////////////////////////////////////////////////////////////////
	// Shift engine

	always_comb begin
		ssm_bits_t nb;
		ssm_word_t nsh;
		ssm_bits_t bpos;
		logic      din;
		logic      lsb;
		logic      idle_lvl;
		nb       = '0;
		nsh      = s_reg.sh;
		bpos     = '0;
		din      = s_reg.sync2[s_reg.dat_pin];
		// Receive modes: bit 0 set means LSB first; transmit is the reverse
		lsb      = s_reg.rx ? s_reg.mode[`SSM_MODE_LSB] : ~s_reg.mode[`SSM_MODE_LSB];
		idle_lvl = s_reg.mode[`SSM_MODE_IHIGH];
		s_next   = s_reg;
		s_next.rx_pulse = 1'b0;
		s_next.sync1 = gpio_in;
		s_next.sync2 = s_reg.sync1;
		s_next.sel_n = ~sel_assert;
		// Low-order bits only: LSB first walks up, MSB first walks down
		bpos = lsb ? s_reg.idx : ssm_bits_t'(s_reg.nbits - `SSM_IDX_ONE - s_reg.idx);
		if (s_reg.rx) begin
			if (lsb) begin
				nsh[bpos[4:0]] = din;
			end else begin
				nsh = {s_reg.sh[`SSM_DW-2:0], din};
			end
		end
		case (s_reg.st)
			SSM_IDLE: begin
				if (take) begin
					if (item.bits == '0) begin
						nb = `SSM_DEF_BITS;
					end else if (item.bits > `SSM_MAX_BITS) begin
						nb = `SSM_MAX_BITS;
					end else begin
						nb = item.bits;
					end
					s_next.nbits   = nb;
					s_next.idx     = '0;
					s_next.rx      = item.rx;
					s_next.mode    = item.mode;
					s_next.sh      = item.rx ? '0 : item.data;
					s_next.clk_pin = clk_pin_sel;
					s_next.dat_pin = data_pin_sel;
					s_next.pin_oe  = '0;
					s_next.pin_oe[clk_pin_sel]  = 1'b1;
					s_next.pin_out[clk_pin_sel] = item.mode[`SSM_MODE_IHIGH];
					s_next.pin_oe[data_pin_sel] = ~item.rx;
					s_next.cnt     = IDLE_CYC;
					s_next.st      = SSM_SETUP;
				end
			end
			SSM_SETUP: begin
				s_next.pin_out[s_reg.clk_pin] = idle_lvl;
				if (!s_reg.rx) begin
					s_next.pin_out[s_reg.dat_pin] = s_reg.sh[bpos[4:0]];
				end
				s_next.cnt = `SSM_CNTW'(s_reg.cnt - `SSM_CNT_ONE);
				if (s_reg.cnt == `SSM_CNT_ONE) begin
					if (s_reg.rx && !s_reg.mode[`SSM_MODE_POST]) begin
						s_next.sh = nsh;
					end
					s_next.pin_out[s_reg.clk_pin] = ~idle_lvl;
					s_next.cnt = ACT_CYC;
					s_next.st  = SSM_ACTIVE;
				end
			end
			SSM_ACTIVE: begin
				s_next.cnt = `SSM_CNTW'(s_reg.cnt - `SSM_CNT_ONE);
				if (s_reg.cnt == `SSM_CNT_ONE) begin
					if (s_reg.rx && s_reg.mode[`SSM_MODE_POST]) begin
						s_next.sh = nsh;
					end
					s_next.pin_out[s_reg.clk_pin] = idle_lvl;
					if (s_reg.idx == ssm_bits_t'(s_reg.nbits - `SSM_IDX_ONE)) begin
						if (s_reg.rx) begin
							s_next.rx_word  = s_reg.mode[`SSM_MODE_POST] ? nsh : s_reg.sh;
							s_next.rx_pulse = 1'b1;
						end
						s_next.st = SSM_IDLE;
					end else begin
						s_next.idx = ssm_bits_t'(s_reg.idx + `SSM_IDX_ONE);
						s_next.cnt = IDLE_CYC;
						s_next.st  = SSM_SETUP;
					end
				end
			end
			default: begin
				s_next.st = SSM_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '{st: SSM_IDLE, sel_n: 1'b1, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign gpio_out = s_reg.pin_out;
	assign gpio_oe  = s_reg.pin_oe;
	assign sel_n    = s_reg.sel_n;
	assign rx_valid = s_reg.rx_pulse;
	assign rx_data  = s_reg.rx_word;
	assign busy     = (s_reg.st != SSM_IDLE) || item_valid;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_default_bits;
		@(posedge mclk) disable iff (!resetn)
		take && (item.bits == '0) |=> s_reg.nbits == `SSM_DEF_BITS;
	endproperty
	a_default_bits: assert property (p_default_bits)
		else $error("default bit count not eight");

	property p_max_bits;
		@(posedge mclk) disable iff (!resetn)
		take && (item.bits > `SSM_MAX_BITS) |=> s_reg.nbits == `SSM_MAX_BITS;
	endproperty
	a_max_bits: assert property (p_max_bits)
		else $error("bit count above 32 not clamped");

	property p_low_bits;
		@(posedge mclk) disable iff (!resetn)
		rx_valid && (s_reg.nbits < `SSM_MAX_BITS) |-> (rx_data >> s_reg.nbits) == '0;
	endproperty
	a_low_bits: assert property (p_low_bits)
		else $error("received bits not in low positions");

	property p_idle_level;
		@(posedge mclk) disable iff (!resetn)
		(s_reg.st == SSM_SETUP) && $past(s_reg.st == SSM_SETUP)
			|-> gpio_out[s_reg.clk_pin] == s_reg.mode[`SSM_MODE_IHIGH];
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("clock not at idle level between pulses");

	property p_active_level;
		@(posedge mclk) disable iff (!resetn)
		s_reg.st == SSM_ACTIVE |-> gpio_out[s_reg.clk_pin] != s_reg.mode[`SSM_MODE_IHIGH];
	endproperty
	a_active_level: assert property (p_active_level)
		else $error("clock not at active level during pulse");

	property p_active_len;
		@(posedge mclk) disable iff (!resetn)
		$rose(s_reg.st == SSM_ACTIVE) |-> s_reg.cnt == ACT_CYC
			##1 (s_reg.st == SSM_ACTIVE)[*2];
	endproperty
	a_active_len: assert property (p_active_len)
		else $error("active phase too short");

	property p_count_down;
		@(posedge mclk) disable iff (!resetn)
		(s_reg.st != SSM_IDLE) && (s_reg.cnt != `SSM_CNT_ONE)
			|=> $stable(s_reg.st) && (s_reg.cnt == `SSM_CNTW'($past(s_reg.cnt) - `SSM_CNT_ONE));
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("phase ended before its count");

	property p_setup_len;
		@(posedge mclk) disable iff (!resetn)
		$rose(s_reg.st == SSM_SETUP) |-> s_reg.cnt == IDLE_CYC;
	endproperty
	a_setup_len: assert property (p_setup_len)
		else $error("idle phase length wrong");

	property p_tx_stable;
		@(posedge mclk) disable iff (!resetn)
		(s_reg.st == SSM_ACTIVE) && !s_reg.rx && $past(s_reg.st == SSM_ACTIVE)
			|-> $stable(gpio_out[s_reg.dat_pin]);
	endproperty
	a_tx_stable: assert property (p_tx_stable)
		else $error("transmit data moved during clock pulse");

	property p_pins;
		@(posedge mclk) disable iff (!resetn)
		take |=> gpio_oe[$past(clk_pin_sel)] && (s_reg.clk_pin == $past(clk_pin_sel));
	endproperty
	a_pins: assert property (p_pins)
		else $error("clock not driven on chosen pin");

	property p_select;
		@(posedge mclk) disable iff (!resetn)
		sel_assert ##1 sel_assert |-> !sel_n;
	endproperty
	a_select: assert property (p_select)
		else $error("select output not asserted");

endmodule : ssm_shift_master

//--- hw/ssm_params.svh
// Purpose: Constants of the synchronous shift master
// Assumes: 25 MHz mclk, 40 ns period
// Notes:   Times in their own unit, cycle counts derived in the top module
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

`define SSM_NPIN        8
`define SSM_PINW        3
`define SSM_DW          32
`define SSM_BW          6
`define SSM_CNTW        22
`define SSM_DEF_BITS    6'h08
`define SSM_MAX_BITS    6'h20
`define SSM_FIFO_DEPTH  32
`define SSM_CYC_NS      40
`define SSM_PERIOD_NS   20000
`define SSM_ACT_NS      2000
`define SSM_NS_PER_US   1000
`define SSM_STRETCH_US  0
`define SSM_CNT_ONE     22'h000001
`define SSM_IDX_ONE     6'h01
`define SSM_MODE_LSB    0
`define SSM_MODE_POST   1
`define SSM_MODE_IHIGH  2

`endif

//--- hw/ssm_pkg.sv
// Purpose: Types of the synchronous shift master
// Assumes: ssm_params.svh on the include path
// Notes:   Command word layout is the packed struct below
`include "ssm_params.svh"

package ssm_pkg;

	typedef enum logic [1:0] {
		SSM_IDLE   = 2'b00,
		SSM_SETUP  = 2'b01,
		SSM_ACTIVE = 2'b10
	} ssm_state_t;

	typedef logic [`SSM_PINW-1:0] ssm_pin_t;
	typedef logic [`SSM_NPIN-1:0] ssm_pins_t;
	typedef logic [`SSM_DW-1:0]   ssm_word_t;
	typedef logic [`SSM_BW-1:0]   ssm_bits_t;

	typedef struct packed {
		logic      rx;
		logic [2:0] mode;
		ssm_bits_t bits;
		ssm_word_t data;
	} ssm_cmd_t;

endpackage : ssm_pkg

//--- hw/ssm_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Read data is a mux over registered storage
`timescale 1ns/1ps

module ssm_fifo #(
	parameter int WIDTH = 42,
	parameter int DEPTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	import ssm_pkg::*;

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} ssm_fifo_st_t;

	ssm_fifo_st_t s_reg;
	ssm_fifo_st_t s_next;
	logic         push;
	logic         pop;

	assign in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
	assign out_valid = s_reg.cnt != '0;
	assign out_data  = s_reg.mem[s_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = AW'(s_reg.wp + 1'b1);
		end
		if (pop) begin
			s_next.rp = AW'(s_reg.rp + 1'b1);
		end
		s_next.cnt = (AW+1)'(s_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	property p_no_overflow;
		@(posedge mclk) disable iff (!resetn)
		(s_reg.cnt <= (AW+1)'(DEPTH)) && (AW'(s_reg.wp - s_reg.rp) == s_reg.cnt[AW-1:0]);
	endproperty
	a_no_overflow: assert property (p_no_overflow)
		else $error("fifo count out of step with pointers");

endmodule : ssm_fifo

//--- testbench/ssm_peer_model.sv
// Purpose: Simple clocked serial peripheral on the far side
// Assumes: Bench resolves the pin levels and pulls
// Notes:   Next read bit shows mid active phase
`timescale 1ns/1ps

module ssm_peer_model (
	input  wire logic        clk_line,
	input  wire logic        data_line,
	input  wire logic        sel_n,
	input  wire logic        idle_high,
	input  wire logic [31:0] resp,
	output logic             dval,
	output logic [31:0]      cap,
	output int               n_cap,
	output int               t_act,
	output int               t_per
);
	int   idx     = 0;
	bit   act     = 0;
	logic sel_was = 1'b1;
	real  t0      = 0;

	assign dval = resp[idx[4:0]];

	// New frame on select, capture on leaving idle, measure phases
	always @(clk_line or sel_n) begin
		if (!sel_n && sel_was) begin
			idx <= 0;
			act = 0;
			cap = '0;
			n_cap = 0;
		end else if (!sel_n && clk_line != idle_high) begin
			cap = {cap[30:0], data_line};
			n_cap++;
			t_per = int'($realtime - t0);
			t0 = $realtime;
			act = 1;
			// Next read bit shows mid active phase
			idx <= #1000 idx + 1;
		end else if (!sel_n && act) begin
			t_act = int'($realtime - t0);
		end
		sel_was = sel_n;
	end
endmodule : ssm_peer_model

//--- testbench/tb_sync_shift_serial_master.sv
// Purpose: Self-checking bench of the shift master
// Assumes: STRETCH_US 0, a bit is 500 mclk cycles
// Notes:   Clock pin pulled down, other pins pulled up
`timescale 1ns/1ps

module tb_sync_shift_serial_master;
	import ssm_pkg::*;
	logic        mclk = 0;
	logic        resetn = 0;
	logic        cmd_valid = 0;
	logic        cmd_rx = 0;
	logic        sel_assert = 0;
	logic        talk = 0;
	logic        idle_high = 0;
	logic [2:0]  cmd_mode = '0;
	ssm_bits_t   cmd_bits = '0;
	ssm_word_t   cmd_data = '0;
	ssm_pin_t    cp = '0;
	ssm_pin_t    dp = 3'h1;
	logic [31:0] resp = 32'h6b3d_2c95;
	logic [31:0] exp_cap;
	logic [2:0]  txm [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
	logic        cmd_ready, sel_n, busy, rx_valid, dval;
	ssm_word_t   rx_data;
	ssm_pins_t   gpio_out, gpio_oe, pin;
	logic [31:0] cap;
	int          n_cap, t_act, t_per, n_exp, acc;
	int          n_fail = 0;
	int          num_checks = 0;

	ssm_shift_master #(.STRETCH_US(0)) uut (.mclk(mclk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rx(cmd_rx),
		.cmd_mode(cmd_mode), .cmd_bits(cmd_bits), .cmd_data(cmd_data),
		.clk_pin_sel(cp), .data_pin_sel(dp), .sel_assert(sel_assert),
		.sel_n(sel_n), .busy(busy), .rx_valid(rx_valid), .rx_data(rx_data),
		.gpio_in(pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

	ssm_peer_model peer (.clk_line(pin[cp]), .data_line(pin[dp]), .sel_n(sel_n),
		.idle_high(idle_high), .resp(resp), .dval(dval), .cap(cap),
		.n_cap(n_cap), .t_act(t_act), .t_per(t_per));

	// Wire levels from all drivers
	always_comb begin
		for (int i = 0; i < 8; i++)
			pin[i] = gpio_oe[i] ? gpio_out[i] : (i == dp && talk && !sel_n) ? dval : (i != cp);
	end

	initial begin
		forever #20 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task final_report();
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	task wait_for(input int w, input int lim);
		for (int i = 0; i <= lim; i++) begin
			@(posedge mclk);
			if ((w == 0 && cmd_ready === 1'b1) || (w == 1 && rx_valid === 1'b1)
				|| (w == 2 && busy === 1'b0)) begin
				#1;
				return;
			end
		end
		n_fail++;
		final_report();
	endtask : wait_for

	task push(input logic r, input logic [2:0] m, input ssm_bits_t b, input ssm_word_t d);
		int n;
		n = (b == 0) ? 8 : (b > 32) ? 32 : b;
		@(posedge mclk) #1;
		cmd_valid = 1;
		cmd_rx = r;
		cmd_mode = m;
		cmd_bits = b;
		cmd_data = d;
		for (int k = 0; k < n && !r; k++) begin
			exp_cap = {exp_cap[30:0], m[0] ? d[n-1-k] : d[k]};
			n_exp++;
		end
		wait_for(0, 100);
		cmd_valid = 0;
	endtask : push

	task begin_op(input ssm_pin_t c, input ssm_pin_t d, input logic ih, input logic tk);
		cp = c;
		dp = d;
		idle_high = ih;
		talk = tk;
		exp_cap = '0;
		n_exp = 0;
		@(posedge mclk) #1;
		sel_assert = 1;
		@(posedge mclk) #1;
		check(sel_n, 0);
	endtask : begin_op

	task end_op(input logic [2:0] m);
		wait_for(2, 40000);
		check(gpio_oe[cp], 1);
		check(gpio_out[cp], m[2]);
		if (!talk) check(cap, exp_cap);
		if (!talk) check(n_cap, n_exp);
		sel_assert = 0;
		@(posedge mclk) #1;
		check(sel_n, 1);
	endtask : end_op

	function automatic logic [31:0] exp_rx(logic [2:0] m, int n);
		logic [31:0] v;
		v = '0;
		for (int k = 0; k < n; k++)
			v[m[0] ? k : n-1-k] = resp[k+m[1]];
		return v;
	endfunction : exp_rx

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge mclk);
		#1 resetn = 1;
		// Transmit modes, default count, wide source
		for (int i = 0; i < 4; i++) begin
			begin_op(3'(i), 3'(7-i), txm[i][2], 0);
			push(0, txm[i], 6'h00, 32'h1b4);
			end_op(txm[i]);
			check(t_act, 2000);
			check(t_per, 20000);
		end
		// Receive modes, counts 8 then 1..7
		for (int m = 0; m < 8; m++) begin
			begin_op(3'(m+1), 3'(m), m[2], 1);
			push(1, 3'(m), 6'(m), 32'h0);
			wait_for(1, 9000);
			check(rx_data, exp_rx(3'(m), (m == 0) ? 8 : m));
			check(gpio_oe[dp], 0);
			end_op(3'(m));
		end
		// Over-long item clamps to 32 bits, then short one in one frame
		begin_op(3'h2, 3'h5, 0, 0);
		push(0, 3'h1, 6'h3f, 32'hd1e2_c3b4);
		push(0, 3'h0, 6'h03, 32'h6);
		end_op(3'h1);
		// Fill command buffer until refused
		begin_op(3'h4, 3'h6, 0, 0);
		acc = 0;
		cmd_rx = 0;
		cmd_mode = 3'h0;
		cmd_bits = 6'h01;
		cmd_data = 32'h1;
		cmd_valid = 1;
		repeat (40) begin
			@(posedge mclk);
			acc += (cmd_ready === 1'b1);
		end
		#1 cmd_valid = 0;
		check(acc, 33);
		exp_cap = 32'hffff_ffff;
		n_exp = 33;
		end_op(3'h0);
		final_report();
	end
endmodule : tb_sync_shift_serial_master
